/* include/cmp_event_pkg.sv */
// constants for the analog compare event logic: register map, fields, timing
// assumes a byte-wide register port with 8-bit addresses
package cmp_event_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h01;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
    // control register fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_CAPTURE = 5;
    localparam int CTL_PIN_EN = 4;
    localparam int CTL_EDGE_HI = 1;
    localparam int CTL_EDGE_LO = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hF3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // status register fields
    localparam int STS_FLAG = 7;
    localparam int STS_RESULT = 6;
    localparam logic [7:0] MASK_RESET = 8'h80;
    // edge select encoding
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // initialization hold
    localparam int HOLD_CYCLES = 63;
    localparam logic [5:0] HOLD_LAST = 6'(HOLD_CYCLES - 1);
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

/* hw/analog_compare_event_logic.sv */
// digital control around an analog comparator: sync, start-up hold, edge flag, irq
// assumes raw_compare_result comes from the analog core asynchronously to clk
// Functional notes
// - after enable, downstream logic holds its value for 63 clock cycles
// - held value resets to zero; true result after hold sets flag
// - held value survives disable; opposite result after re-enable sets flag
// - capture route enable forwards gated result to timer capture channel 5
// - only the synchronized result feeds status bit and flag setting
// - edge select picks rising, falling, either, or no flag setting
// - interrupt request high while irq enable, irq mask bit 7 and event flag are all set
// - writing one clears the flag, zero leaves it, events set it
// - status bit 7 is the flag (write one to clear), bit 6 the synced result, read only
// - pin enable drives the raw unsynchronized result to the output pin
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module analog_compare_event_logic
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [cmp_event_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cmp_event_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [cmp_event_pkg::DATA_W-1:0] reg_rdata,
    // analog core
    input wire logic raw_compare_result,
    output logic comparator_enable,
    // timer capture channel 5
    output logic capture_ch5_in,
    // output pin
    output logic result_pin_out,
    output logic result_pin_oe,
    // interrupt
    output logic irq
);
    import cmp_event_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // edge decode shared by flag logic

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_RUN} phase_e;

    phase_e phase_r, phase_nxt;
    logic [5:0] hold_cnt_r, hold_cnt_nxt;
    logic [7:0] control_r, control_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic flag_r, flag_nxt;
    logic sync1_r, sync1_nxt;
    logic sync2_r, sync2_nxt;
    logic gated_r, gated_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic capture_r, capture_nxt;
    logic pin_r, pin_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic irq_r, irq_nxt;
    logic wr_ctl, wr_sts, wr_mask;
    logic event_hit;

    assign wr_ctl = reg_write && (reg_addr == OFS_CONTROL);
    assign wr_sts = reg_write && (reg_addr == OFS_STATUS);
    assign wr_mask = reg_write && (reg_addr == OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // sync, hold and edge detection

    // gated_r is the held value: it only follows the synchronizer in ST_RUN,
    // so a disable freezes it and the next hold compares against it
    assign event_hit = (phase_r == ST_RUN)
        && edge_hit(control_r[CTL_EDGE_HI:CTL_EDGE_LO], gated_r, sync2_r);

    always_comb
    begin
        sync1_nxt = raw_compare_result;
        sync2_nxt = sync1_r;
        phase_nxt = phase_r;
        hold_cnt_nxt = hold_cnt_r;
        gated_nxt = gated_r;
        case (phase_r)
            ST_OFF:
            begin
                if (wr_ctl && reg_wdata[CTL_ENABLE])
                begin
                    phase_nxt = ST_HOLD;
                    hold_cnt_nxt = 6'h00;
                end
            end
            ST_HOLD:
            begin
                // raw path ignored while counting out the start-up window
                if (hold_cnt_r == HOLD_LAST)
                    phase_nxt = ST_RUN;
                else
                    hold_cnt_nxt = hold_cnt_r + 6'h01;
            end
            ST_RUN:
            begin
                gated_nxt = sync2_r;
            end
            default: phase_nxt = ST_OFF;
        endcase
        if (wr_ctl && !reg_wdata[CTL_ENABLE])
            phase_nxt = ST_OFF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and flag

    always_comb
    begin
        control_nxt = control_r;
        mask_nxt = mask_r;
        flag_nxt = flag_r;
        if (wr_ctl)
            control_nxt = reg_wdata & CTL_WRITE_MASK;
        if (wr_mask)
            mask_nxt = reg_wdata & MASK_RESET;
        if (wr_sts && reg_wdata[STS_FLAG])
            flag_nxt = 1'b0;
        // set beats a same-cycle clear
        if (event_hit)
            flag_nxt = 1'b1;
        rdata_nxt = READ_IDLE;
        if (reg_read)
        begin
            case (reg_addr)
                OFS_CONTROL: rdata_nxt = control_r;
                OFS_STATUS: rdata_nxt = {flag_r, sync2_r, 6'h00};
                OFS_IRQ_MASK: rdata_nxt = mask_r;
                default: rdata_nxt = READ_IDLE;
            endcase
        end
        capture_nxt = control_nxt[CTL_CAPTURE] & gated_nxt;
        pin_oe_nxt = control_nxt[CTL_PIN_EN];
        // the pin is registered here, so it trails the raw result by one clock
        pin_nxt = control_nxt[CTL_PIN_EN] & raw_compare_result;
        irq_nxt = control_nxt[CTL_IRQ_EN] & mask_nxt[STS_FLAG] & flag_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            phase_r <= ST_OFF;
            hold_cnt_r <= 6'h00;
            control_r <= CTL_RESET;
            mask_r <= MASK_RESET;
            flag_r <= 1'b0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            gated_r <= 1'b0;
            rdata_r <= READ_IDLE;
            capture_r <= 1'b0;
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            control_r <= control_nxt;
            mask_r <= mask_nxt;
            flag_r <= flag_nxt;
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            gated_r <= gated_nxt;
            rdata_r <= rdata_nxt;
            capture_r <= capture_nxt;
            pin_r <= pin_nxt;
            pin_oe_r <= pin_oe_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign comparator_enable = control_r[CTL_ENABLE];
    assign capture_ch5_in = capture_r;
    assign result_pin_out = pin_r;
    assign result_pin_oe = pin_oe_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

/* tb/analog_core_model.sv */
// behavioural analog comparator core feeding the raw result
// assumes the bench sets the wanted comparison through level
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
(
    // control
    input wire logic comparator_enable,
    input wire logic level,
    // result
    output logic raw_compare_result
);
    // a powered-down core gives low, never a stale comparison
    assign raw_compare_result = comparator_enable & level;
endmodule
`default_nettype wire

/* tb/analog_compare_event_logic_assertions.sv */
// port checker for the compare event logic
// bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module analog_compare_event_logic_checker
(
    // bus
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // core, pin, irq
    input wire logic raw_compare_result,
    input wire logic comparator_enable,
    input wire logic result_pin_out,
    input wire logic result_pin_oe,
    input wire logic irq
);
    import cmp_event_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_read_slot: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
        else $error("stray read data");
    chk_status_low: assert property (reg_read && reg_addr == OFS_STATUS |=>
        reg_rdata[5:0] == 6'h00) else $error("status low bits set");
    chk_ctl_read: assert property (reg_read && reg_addr == OFS_CONTROL |=>
        reg_rdata[7] == comparator_enable) else $error("enable readback");
    chk_unmapped_zero: assert property (reg_read && reg_addr > OFS_IRQ_MASK |=>
        reg_rdata == 8'h00) else $error("unmapped read");
    chk_enable_set: assert property (reg_write && reg_addr == OFS_CONTROL &&
        reg_wdata[7] |=> comparator_enable) else $error("enable lost");
    chk_pin_raw: assert property (result_pin_out |->
        result_pin_oe && $past(raw_compare_result)) else $error("pin source");
    chk_irq_masked: assert property (reg_write && reg_addr == OFS_IRQ_MASK &&
        !reg_wdata[7] |=> !irq) else $error("irq not masked");
    chk_irq_off: assert property (reg_write && reg_addr == OFS_CONTROL &&
        !reg_wdata[6] |=> !irq) else $error("irq not disabled");
endmodule
bind analog_compare_event_logic analog_compare_event_logic_checker u_checker (.clk, .reset_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .raw_compare_result,
    .comparator_enable, .result_pin_out, .result_pin_oe, .irq);
`default_nettype wire

/* tb/analog_compare_event_logic_tb.sv */
// self-checking bench for the compare event logic
// assumes the package first and the checker bound
`timescale 1ns/1ps
`default_nettype none
module analog_compare_event_logic_tb;
    import cmp_event_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic level = 1'b0;
    logic [7:0] reg_rdata;
    logic raw_compare_result, comparator_enable, capture_ch5_in, result_pin_out;
    logic result_pin_oe, irq;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    analog_compare_event_logic u_analog_compare_event_logic (.clk, .reset_n, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .raw_compare_result,
        .comparator_enable, .capture_ch5_in, .result_pin_out, .result_pin_oe, .irq);
    analog_core_model u_analog_core_model (.comparator_enable, .level, .raw_compare_result);
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task print_verdict;
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // step off the edge so outputs launched by it have settled
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task lvl(input logic v);
        @(posedge clk) level <= v;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clk) reg_write <= 1'b0;
    endtask
    // only the masked bits are judged; the rest may move
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk) {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clk) reg_read <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    task test_reset;
        rd(OFS_CONTROL, 8'h00, 8'hFF);
        rd(OFS_STATUS, 8'h00, 8'hFF);
        rd(OFS_IRQ_MASK, 8'h80, 8'hFF);
        rd(8'h05, 8'h00, 8'hFF);
    endtask
    task test_hold;
        lvl(1'b1);
        wr(OFS_CONTROL, 8'hE0 | EDGE_RISE);
        cyc(55);
        rd(OFS_STATUS, 8'h00, 8'h80);
        cyc(10);
        rd(OFS_STATUS, 8'hC0, 8'hC0);
        chk({6'h00, irq, capture_ch5_in}, 8'h03);
    endtask
    task test_clear;
        wr(OFS_IRQ_MASK, 8'h00);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        wr(OFS_IRQ_MASK, 8'h80);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, 8'h80, 8'h80);
        wr(OFS_STATUS, 8'h80);
        rd(OFS_STATUS, 8'h00, 8'h80);
        chk({7'h00, irq}, 8'h00);
    endtask
    task test_edges;
        for (int e = 0; e < 4; e++)
        begin
            wr(OFS_CONTROL, 8'h80 | 8'(e));
            lvl(1'b0);
            cyc(6);
            wr(OFS_STATUS, 8'h80);
            lvl(1'b1);
            cyc(6);
            rd(OFS_STATUS, {e[0], 7'h00}, 8'h80);
            wr(OFS_STATUS, 8'h80);
            lvl(1'b0);
            cyc(6);
            rd(OFS_STATUS, {e[1], 7'h00}, 8'h80);
        end
    endtask
    task test_reenable;
        wr(OFS_CONTROL, 8'h90);
        lvl(1'b1);
        cyc(6);
        chk({6'h00, result_pin_oe, result_pin_out}, 8'h03);
        chk({6'h00, irq, capture_ch5_in}, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        lvl(1'b0);
        wr(OFS_STATUS, 8'h80);
        wr(OFS_CONTROL, 8'h80 | EDGE_FALL);
        cyc(55);
        rd(OFS_STATUS, 8'h00, 8'h80);
        cyc(10);
        rd(OFS_STATUS, 8'h80, 8'h80);
    endtask
    // a hung handshake would otherwise stall the run for good
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            $display("unexpected at %0t: timeout", $time);
            print_verdict();
        end
    end
    initial
    begin
        cyc(10);
        reset_n <= 1'b1;
        test_reset();
        test_hold();
        test_clear();
        test_edges();
        test_reenable();
        print_verdict();
    end
endmodule
`default_nettype wire
